/* usm_regs.svh */
// Constant encodings, reset values and counts of the SPI master transfer.
`ifndef USM_REGS_SVH
`define USM_REGS_SVH
`define USM_MODE_SPI 2'h3
`define USM_LAST_EDGE 4'hF
`define USM_RX_DEPTH 2'h2
`define USM_BYTE_ZERO 8'h00
`define USM_DIV_ZERO 12'h000
`define USM_ONE_ENTRY 2'h1
`define USM_EDGE_ZERO 4'h0
`define USM_RX_EMPTY 2'h0
`endif

/* usm_pkg.sv */
// Types shared by the SPI master transfer block.
package usm_pkg;
   typedef enum logic [0:0] {
      USM_IDLE = 1'b0,
      USM_SHIFT = 1'b1
   } usm_state_type;

   typedef struct packed {
      usm_state_type st;
      logic [7:0] tx_buf;
      logic tx_buf_full;
      logic [7:0] tx_shift;
      logic [7:0] rx_shift;
      logic [3:0] edge_idx;
      logic [11:0] baud_cnt;
      logic [1:0][7:0] rx_buf;
      logic [1:0] rx_cnt;
      logic tx_complete;
      logic sck;
      logic mosi;
      logic tx_on;
      logic rx_on;
      logic master_on;
      logic rx_ready;
      logic tx_free;
      logic err_flag;
   } usm_core_type;
endpackage

/* usm_spi_master.sv */
// Serial port data transfer logic running as an SPI master.
// How it works
// - Transmit pin driven as serial data output.
// - Enabled receiver takes serial input pin.
// - Transfer clock pin always the shift clock.
// - Data register write starts each transfer.
// - Buffer loads shifter once shifter is free.
// - Overflow drops newest byte, keeps older ones.
// - Complete and empty flags as normal port.
// - Error flags unused and read zero.
// - Disabling sides behaves as normal port.
// - Transmitter is double buffered.
// - Receiver has one extra buffer level.
// - No write collision flag; writes queue while buffer free.
// - Speed set by divider only.
// - Master only, no slave select.
// - Polarity, phase, order act as SPI.
// - Mode active only when mode select is 11.
// - Shift and sample on opposite edges.
// - Eight bit frames, order selectable.
// - Clock is system over twice divider plus two.
`include "usm_regs.svh"
module usm_spi_master
   import usm_pkg::*;
(
   // Clock, reset and enable.
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   // Configuration.
   input wire logic [1:0] i_port_mode_select,
   input wire logic i_tx_enable_bit,
   input wire logic i_rx_enable_bit,
   input wire logic i_clock_polarity_bit,
   input wire logic i_clock_phase_bit,
   input wire logic i_bit_order_bit,
   input wire logic [11:0] i_baud_divider,
   // Data register access.
   input wire logic i_data_register_wr,
   input wire logic [7:0] i_data_register_wdata,
   input wire logic i_data_register_rd,
   input wire logic i_tx_complete_clr,
   // Serial pins.
   input wire logic i_serial_in_pin,
   output logic o_serial_out_pin,
   output logic o_serial_out_oe,
   output logic o_transfer_clock_pin,
   output logic o_transfer_clock_oe,
   output logic o_serial_in_used,
   // Data and status.
   output logic [7:0] o_data_register_rdata,
   output logic o_rx_complete_flag,
   output logic o_tx_complete_flag,
   output logic o_tx_buffer_empty_flag,
   output logic o_frame_error_flag,
   output logic o_overrun_flag,
   output logic o_parity_error_flag
);
   usm_core_type r;
   usm_core_type next_r;
   logic tick;
   logic frame_done;
   logic sample_edge;
   logic push;
   logic pop;
   logic [1:0] wr_idx;

   function automatic logic first_bit(input logic [7:0] v, input logic lsb);
      first_bit = lsb ? v[0] : v[7];
   endfunction

   function automatic logic [7:0] shift_out(input logic [7:0] v,
                                            input logic lsb);
      shift_out = lsb ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
   endfunction

   always_comb begin
      next_r = r;
      tick = 1'b0;
      frame_done = 1'b0;
      sample_edge = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      wr_idx = r.rx_cnt;
      if (i_clk_en) begin
         next_r.master_on = (i_port_mode_select == `USM_MODE_SPI);
         // Transmitter stays on until queued data has gone out.
         next_r.tx_on = next_r.master_on && (i_tx_enable_bit ||
            r.st == USM_SHIFT || r.tx_buf_full);
         next_r.rx_on = next_r.master_on && i_rx_enable_bit;
         // A write is queued while the buffer is free, or below in the cycle the shifter takes the buffered byte.
         if (i_data_register_wr && r.master_on && i_tx_enable_bit &&
             !r.tx_buf_full) begin
            next_r.tx_buf = i_data_register_wdata;
            next_r.tx_buf_full = 1'b1;
         end
         if (r.st == USM_SHIFT) begin
            tick = (r.baud_cnt == `USM_DIV_ZERO);
            if (tick) begin
               next_r.baud_cnt = i_baud_divider;
               next_r.sck = ~r.sck;
               next_r.edge_idx = r.edge_idx + 4'h1;
               // Even edges lead; phase picks sample edge.
               sample_edge = (r.edge_idx[0] == i_clock_phase_bit);
               if (sample_edge) begin
                  next_r.rx_shift = i_bit_order_bit ?
                     {i_serial_in_pin, r.rx_shift[7:1]} :
                     {r.rx_shift[6:0], i_serial_in_pin};
               end else if (i_clock_phase_bit) begin
                  next_r.mosi = first_bit(r.tx_shift, i_bit_order_bit);
                  next_r.tx_shift = shift_out(r.tx_shift, i_bit_order_bit);
               end else begin
                  next_r.tx_shift = shift_out(r.tx_shift, i_bit_order_bit);
                  next_r.mosi = first_bit(next_r.tx_shift, i_bit_order_bit);
               end
               if (r.edge_idx == `USM_LAST_EDGE) begin
                  frame_done = 1'b1;
                  next_r.st = USM_IDLE;
                  next_r.sck = i_clock_polarity_bit;
                  if (!r.tx_buf_full) begin
                     next_r.tx_complete = 1'b1;
                  end
                  push = r.rx_on;
               end
            end else begin
               next_r.baud_cnt = r.baud_cnt - 12'h001;
            end
         end else begin
            next_r.sck = i_clock_polarity_bit;
         end
         // Shifter takes the queued byte as soon as it is free.
         if ((r.st == USM_IDLE || frame_done) && r.tx_buf_full &&
             r.master_on) begin
            next_r.st = USM_SHIFT;
            next_r.tx_buf_full = 1'b0;
            next_r.tx_shift = r.tx_buf;
            // Phase 1 keeps the line still here; its leading edge sets it.
            if (!i_clock_phase_bit) begin
               next_r.mosi = first_bit(r.tx_buf, i_bit_order_bit);
            end
            next_r.edge_idx = `USM_EDGE_ZERO;
            next_r.baud_cnt = i_baud_divider;
            next_r.sck = i_clock_polarity_bit;
            if (i_data_register_wr && i_tx_enable_bit) begin
               next_r.tx_buf = i_data_register_wdata;
               next_r.tx_buf_full = 1'b1;
            end
         end
         // Completion set wins over a clear in the same cycle.
         if (i_tx_complete_clr && !(frame_done && !r.tx_buf_full)) begin
            next_r.tx_complete = 1'b0;
         end
         // Receive buffer: head at entry 0; newest byte dropped when full.
         pop = i_data_register_rd && (r.rx_cnt != `USM_RX_EMPTY);
         if (pop) begin
            next_r.rx_buf[0] = r.rx_buf[1];
            wr_idx = r.rx_cnt - `USM_ONE_ENTRY;
         end
         if (push && (r.rx_cnt != `USM_RX_DEPTH || pop)) begin
            next_r.rx_buf[wr_idx[0]] = next_r.rx_shift;
            next_r.rx_cnt = wr_idx + `USM_ONE_ENTRY;
         end else begin
            next_r.rx_cnt = wr_idx;
         end
         // A disabled receiver flushes its buffer.
         if (!r.rx_on) begin
            next_r.rx_cnt = `USM_RX_EMPTY;
         end
         // Status flags are registered from the next state.
         next_r.rx_ready = (next_r.rx_cnt != `USM_RX_EMPTY);
         next_r.tx_free = !next_r.tx_buf_full;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         r.st <= USM_IDLE;
         r.tx_buf <= `USM_BYTE_ZERO;
         r.tx_buf_full <= 1'b0;
         r.tx_shift <= `USM_BYTE_ZERO;
         r.rx_shift <= `USM_BYTE_ZERO;
         r.edge_idx <= `USM_EDGE_ZERO;
         r.baud_cnt <= `USM_DIV_ZERO;
         r.rx_buf <= {`USM_BYTE_ZERO, `USM_BYTE_ZERO};
         r.rx_cnt <= `USM_RX_EMPTY;
         r.tx_complete <= 1'b0;
         r.sck <= 1'b0;
         r.mosi <= 1'b1;
         r.tx_on <= 1'b0;
         r.rx_on <= 1'b0;
         r.master_on <= 1'b0;
         r.rx_ready <= 1'b0;
         r.tx_free <= 1'b1;
         r.err_flag <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   assign o_serial_out_pin = r.mosi;
   assign o_serial_out_oe = r.tx_on;
   assign o_transfer_clock_pin = r.sck;
   assign o_transfer_clock_oe = r.master_on;
   assign o_serial_in_used = r.rx_on;
   assign o_data_register_rdata = r.rx_buf[0];
   assign o_rx_complete_flag = r.rx_ready;
   assign o_tx_complete_flag = r.tx_complete;
   assign o_tx_buffer_empty_flag = r.tx_free;
   // Error flags come from a flip-flop that never leaves zero.
   assign o_frame_error_flag = r.err_flag;
   assign o_overrun_flag = r.err_flag;
   assign o_parity_error_flag = r.err_flag;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);

   sequence s_last_tick;
      i_clk_en && r.st == USM_SHIFT && tick && r.edge_idx == `USM_LAST_EDGE;
   endsequence

   property p_idle_clock;
      r.st == USM_IDLE && $past(r.st == USM_IDLE) && i_clk_en &&
         $past(i_clk_en) && $stable(i_clock_polarity_bit)
         |-> r.sck == i_clock_polarity_bit;
   endproperty
   a_idle_clock: assert property (p_idle_clock)
      else $error("clock not idle at polarity");

   property p_start_needs_write;
      $rose(r.st == USM_SHIFT) |-> $past(r.tx_buf_full);
   endproperty
   a_start_needs_write: assert property (p_start_needs_write)
      else $error("frame started without a queued byte");

   property p_errors_zero;
      !o_frame_error_flag && !o_overrun_flag && !o_parity_error_flag;
   endproperty
   a_errors_zero: assert property (p_errors_zero)
      else $error("error flag not zero");

   property p_overflow_keeps;
      i_clk_en && r.rx_cnt == `USM_RX_DEPTH && r.rx_on && !i_data_register_rd
         |=> $stable(r.rx_buf) && r.rx_cnt == `USM_RX_DEPTH;
   endproperty
   a_overflow_keeps: assert property (p_overflow_keeps)
      else $error("full receive buffer changed");

   property p_queue_while_busy;
      i_clk_en && r.st == USM_SHIFT && !r.tx_buf_full && !frame_done &&
         i_data_register_wr && i_tx_enable_bit && r.master_on
         |=> r.tx_buf_full && !o_tx_buffer_empty_flag && r.st == USM_SHIFT;
   endproperty
   a_queue_while_busy: assert property (p_queue_while_busy)
      else $error("write not queued during shift");

   property p_frame_end;
      s_last_tick ##0 !r.tx_buf_full |=> r.st == USM_IDLE && r.tx_complete;
   endproperty
   a_frame_end: assert property (p_frame_end)
      else $error("frame end not reported");

   property p_sck_rate;
      $past(r.st == USM_SHIFT) && r.st == USM_SHIFT && $changed(r.sck)
         |-> $past(r.baud_cnt) == `USM_DIV_ZERO;
   endproperty
   a_sck_rate: assert property (p_sck_rate)
      else $error("clock toggled off a divider tick");

   property p_out_enable;
      i_clk_en && i_tx_enable_bit && i_port_mode_select == `USM_MODE_SPI
         |=> o_serial_out_oe;
   endproperty
   a_out_enable: assert property (p_out_enable)
      else $error("serial out not driven");

   property p_back_to_back;
      s_last_tick ##0 r.tx_buf_full |=> r.st == USM_SHIFT &&
         r.edge_idx == `USM_EDGE_ZERO && !r.tx_buf_full;
   endproperty
   a_back_to_back: assert property (p_back_to_back)
      else $error("queued byte not loaded at frame end");

   property p_rx_push;
      s_last_tick ##0 r.rx_on && r.rx_cnt == `USM_RX_EMPTY &&
         !i_data_register_rd |=> o_rx_complete_flag &&
         r.rx_cnt == `USM_ONE_ENTRY;
   endproperty
   a_rx_push: assert property (p_rx_push)
      else $error("received byte not buffered");

   property p_tx_oe_hold;
      i_clk_en && r.st == USM_SHIFT && i_port_mode_select == `USM_MODE_SPI
         |=> o_serial_out_oe;
   endproperty
   a_tx_oe_hold: assert property (p_tx_oe_hold)
      else $error("serial out released mid frame");

   property p_mode_off;
      i_clk_en && i_port_mode_select != `USM_MODE_SPI
         |=> !o_transfer_clock_oe;
   endproperty
   a_mode_off: assert property (p_mode_off)
      else $error("clock driven outside master mode");
endmodule

/* usm_slave_model.sv */
// Behavioural SPI slave that answers with a counting byte stream.
module usm_slave_model (
   // Serial wires.
   input wire logic i_sck,
   input wire logic i_mosi,
   output logic o_miso,
   // Mode and control.
   input wire logic i_cpol,
   input wire logic i_cpha,
   input wire logic i_lsb,
   input wire logic i_load,
   input wire logic [7:0] i_byte,
   output logic [7:0] o_rx_byte
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] tx_byte;
   logic [7:0] rx_sr;
   int cnt;
   always @(posedge i_load) begin
      tx_byte = i_byte;
      cnt = 0;
   end
   // Input is taken on the sample edge; output moves right after it.
   always @(i_sck) begin
      if (i_sck === (i_cpol ^ !i_cpha)) begin
         rx_sr[i_lsb ? cnt : 7 - cnt] = i_mosi;
         cnt = cnt + 1;
         if (cnt == 8) begin
            o_rx_byte = rx_sr;
            tx_byte = tx_byte + 8'h01;
            cnt = 0;
         end
      end
   end
   assign o_miso = tx_byte[i_lsb ? cnt : 7 - cnt];
endmodule

/* usm_spi_master_test.sv */
// Self-checking bench of the SPI master transfer block.
module usm_spi_master_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, wr = 0, rd = 0, clr = 0, txe = 0, rxe = 0;
   logic cpol = 0, cpha = 0, lsb = 0, load = 0, ce = 1;
   logic [1:0] mode = 0;
   logic [11:0] div = 0;
   logic [7:0] wdata = 0, sbyte = 0;
   logic miso, mosi, mosi_oe, sck, sck_oe, in_used, rxc, txc, empty;
   logic fe, overrun_flag, pe;
   logic [7:0] rdata, srx;
   int error_cnt = 0, total_checks = 0;
   always #50 clk = ~clk;
   usm_spi_master DUT (.i_ref_clk(clk), .i_sys_rst(rst), .i_clk_en(ce),
      .i_port_mode_select(mode), .i_tx_enable_bit(txe),
      .i_rx_enable_bit(rxe), .i_clock_polarity_bit(cpol),
      .i_clock_phase_bit(cpha), .i_bit_order_bit(lsb),
      .i_baud_divider(div), .i_data_register_wr(wr),
      .i_data_register_wdata(wdata), .i_data_register_rd(rd),
      .i_tx_complete_clr(clr), .i_serial_in_pin(miso),
      .o_serial_out_pin(mosi), .o_serial_out_oe(mosi_oe),
      .o_transfer_clock_pin(sck), .o_transfer_clock_oe(sck_oe),
      .o_serial_in_used(in_used), .o_data_register_rdata(rdata),
      .o_rx_complete_flag(rxc), .o_tx_complete_flag(txc),
      .o_tx_buffer_empty_flag(empty), .o_frame_error_flag(fe),
      .o_overrun_flag(overrun_flag), .o_parity_error_flag(pe));
   usm_slave_model slave (.i_sck(sck), .i_mosi(mosi), .o_miso(miso),
      .i_cpol(cpol), .i_cpha(cpha), .i_lsb(lsb), .i_load(load),
      .i_byte(sbyte), .o_rx_byte(srx));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Expected half period of the serial clock in ns.
   function automatic int half_ns(input logic [11:0] d);
      return (int'(d) + 1) * 100;
   endfunction
   // Byte value k steps on from v, wrapping within eight bits.
   function automatic logic [7:0] nxt(input logic [7:0] v,
                                      input logic [7:0] k);
      return v + k;
   endfunction
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Waits for a free transmit buffer, then writes one byte.
   task automatic put(input logic [7:0] b);
      int i;
      i = 0;
      while (empty !== 1'b1 && i < 2000) begin
         tick(1);
         i++;
      end
      wr = 1;
      wdata = b;
      tick(1);
      wr = 0;
   endtask
   task automatic pop();
      rd = 1;
      tick(1);
      rd = 0;
   endtask
   task automatic wait_done();
      int i;
      i = 0;
      while (txc !== 1'b1 && i < 2000) begin
         tick(1);
         i++;
      end
      chk(i < 2000, 1);
   endtask
   // The slave is reloaded only once the clock has settled at its idle.
   task automatic prep();
      tick(3);
      sbyte = 8'($urandom);
      load = 1;
      tick(1);
      load = 0;
      clr = 1;
      tick(1);
      clr = 0;
      chk(txc, 0);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      error_cnt++;
      end_of_test();
   end
   initial begin
      int i;
      logic [7:0] b;
      time t0;
      logic s0;
      i = $urandom(41);
      tick(3);
      rst = 0;
      chk({mosi, empty, txc, rxc}, 4'hC);
      mode = 2'h3;
      txe = 1;
      rxe = 1;
      tick(2);
      chk({mosi_oe, in_used, sck_oe}, 3'h7);
      for (i = 0; i < 8; i++) begin
         {lsb, cpha, cpol} = i[2:0];
         div = 12'($urandom % 4);
         prep();
         b = 8'($urandom);
         put(b);
         @(sck);
         t0 = $time;
         @(sck);
         chk(32'($time - t0), half_ns(div));
         tick(1);
         wait_done();
         chk(srx, b);
         chk(rxc, 1);
         chk(rdata, sbyte);
         pop();
         chk(rxc, 0);
         chk(sck, cpol);
         chk({fe, overrun_flag, pe}, 0);
         $display("mode test %0d done", i);
      end
      {lsb, cpha, cpol, div} = 0;
      prep();
      b = 8'($urandom);
      put(b);
      put(b + 8'h01);
      tick(2);
      chk(empty, 0);
      put(b + 8'h02);
      ce = 0;
      s0 = sck;
      tick(4);
      chk(sck, s0);
      chk(empty, 0);
      ce = 1;
      wait_done();
      chk(srx, nxt(b, 8'h02));
      chk(rdata, sbyte);
      pop();
      chk(rdata, nxt(sbyte, 8'h01));
      pop();
      chk(rxc, 0);
      $display("queue test done");
      rxe = 0;
      prep();
      chk(in_used, 0);
      put(8'($urandom));
      wait_done();
      chk(rxc, 0);
      $display("receiver off test done");
      rxe = 1;
      mode = 2'h2;
      prep();
      put(8'($urandom));
      tick(3);
      chk({empty, sck_oe, txc, mosi_oe}, 4'h8);
      $display("mode select test done");
      end_of_test();
   end
endmodule
